// ==== core/pin_strap_pkg.sv ====
/*
 * Constants, types and decoding functions for the pin-strapped converter
 * configuration block. Assumes one master clock domain; every user of this
 * package imports it whole.
 */
package pin_strap_pkg;

	// ==========================================================================
	// Word layout
	// ==========================================================================
	localparam int         WORD_BITS        = 32;
	localparam int         HDR_BITS         = 8;
	localparam int         DATA_BITS        = 24;
	localparam int         HDR_RESET_NEEDED = 7;
	localparam int         HDR_NOT_SETTLED  = 6;
	localparam int         HDR_SATURATED    = 5;
	localparam int         HDR_FILTER_SINC5 = 4;
	localparam logic [5:0] LAST_BIT_INDEX   = 6'h1F;

	// ==========================================================================
	// Rates, dividers and reset values
	// ==========================================================================
	localparam logic [3:0]  ONE_SHOT_BASE  = 4'hC;
	localparam logic [5:0]  MOD_DIV_FAST   = 6'h04;
	localparam logic [5:0]  MOD_DIV_MEDIAN = 6'h08;
	localparam logic [5:0]  MOD_DIV_LOW    = 6'h20;
	localparam logic [10:0] DEC_X32        = 11'h020;
	localparam logic [10:0] DEC_X64        = 11'h040;
	localparam logic [10:0] DEC_X128       = 11'h080;
	localparam logic [10:0] DEC_X1024      = 11'h400;
	localparam logic [1:0]  BCLK_DIV1      = 2'h0;
	localparam logic [1:0]  BCLK_DIV2      = 2'h1;
	localparam logic [2:0]  BOOT_CYCLES    = 3'h5;
	localparam int          SYNC_PIN_COUNT = 10;

	typedef enum logic [1:0] {PM_LOW, PM_MEDIAN, PM_FAST} power_mode_t;

	typedef struct packed {
		power_mode_t power;
		logic [1:0]  bclk_sel;
		logic        one_shot;
	} op_setting_t;

	// Select code to power mode, bit clock divide and conversion type.
	function automatic op_setting_t decode_operating(input logic [3:0] code);
		op_setting_t r;
		r.power    = PM_LOW;
		r.bclk_sel = BCLK_DIV1;
		r.one_shot = 1'b0;
		if (code < ONE_SHOT_BASE) begin
			r.power    = power_mode_t'(code[3:2]);
			r.bclk_sel = code[1:0];
		end else begin
			r.one_shot = 1'b1;
			unique case (code[1:0])
				2'h0: r.power = PM_LOW;
				2'h1: r.power = PM_MEDIAN;
				2'h2: begin
					r.power    = PM_FAST;
					r.bclk_sel = BCLK_DIV2;
				end
				2'h3: r.power = PM_FAST;
			endcase
		end
		return r;
	endfunction

	// Modulator division fixed by power mode.
	function automatic logic [5:0] modulator_divide(input power_mode_t pm);
		logic [5:0] d;
		d = MOD_DIV_LOW;
		unique case (pm)
			PM_FAST:   d = MOD_DIV_FAST;
			PM_MEDIAN: d = MOD_DIV_MEDIAN;
			PM_LOW:    d = MOD_DIV_LOW;
			default:   d = MOD_DIV_LOW;
		endcase
		return d;
	endfunction

	// Rate-select pins to decimation ratio.
	function automatic logic [10:0] decimation_ratio(input logic [1:0] sel);
		logic [10:0] r;
		r = DEC_X32;
		unique case (sel)
			2'h0: r = DEC_X32;
			2'h1: r = DEC_X64;
			2'h2: r = DEC_X128;
			2'h3: r = DEC_X1024;
		endcase
		return r;
	endfunction

endpackage

// ==== core/pin_sync.sv ====
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes pins are asynchronous to clock_in; level rises once the second
 * and third stages agree high, and falls as soon as they differ.
 */
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] pins_in,
	output logic      [WIDTH-1:0] level_out
);
	import pin_strap_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	// ==========================================================================
	// Next state
	// ==========================================================================
	// The first stage is read only by the second, so metastability cannot leak.
	always_comb begin
		st_d       = st_q;
		st_d.s1    = pins_in;
		st_d.s2    = st_q.s1;
		st_d.s3    = st_q.s2;
		st_d.level = (st_q.s2 & st_q.s3) | (st_q.level & ~(st_q.s2 ^ st_q.s3));
	end

	// Register the whole state.
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level_out = st_q.level;

endmodule // pin_sync

// ==== core/word_rate_timer.sv ====
/*
 * Modulator and decimation counters that pace the output words.
 * Assumes the divide and ratio inputs are steady between restarts.
 */
`timescale 1ns/1ns
module word_rate_timer (
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	input  wire logic        restart_in,
	input  wire logic [5:0]  mod_div_in,
	input  wire logic [10:0] dec_ratio_in,
	input  wire logic        one_shot_in,
	output logic             word_tick_out
);
	import pin_strap_pkg::*;

	typedef struct packed {
		logic [5:0]  mod_cnt;
		logic [10:0] dec_cnt;
		logic        armed;
		logic        tick;
	} timer_state_t;

	timer_state_t st_q;
	timer_state_t st_d;

	// ==========================================================================
	// Counting
	// ==========================================================================
	// One word per ratio modulator periods; one-shot fires once per restart.
	always_comb begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		if (restart_in) begin
			st_d.mod_cnt = '0;
			st_d.dec_cnt = '0;
			st_d.armed   = 1'b1;
		end else if (st_q.mod_cnt == mod_div_in - 6'h01) begin
			st_d.mod_cnt = '0;
			if (st_q.dec_cnt == dec_ratio_in - 11'h001) begin
				st_d.dec_cnt = '0;
				st_d.tick    = !one_shot_in || st_q.armed;
				st_d.armed   = 1'b0;
			end else begin
				st_d.dec_cnt = st_q.dec_cnt + 11'h001;
			end
		end else begin
			st_d.mod_cnt = st_q.mod_cnt + 6'h01;
		end
	end

	// Register the whole state.
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign word_tick_out = st_q.tick;

endmodule // word_rate_timer

// ==== core/pin_strap_mode_decoder.sv ====
/*
 * Pin-strapped configuration of a multichannel converter: decodes the
 * operating, filter, rate and standby straps, paces output words and shifts
 * each channel's header and result out on its serial lane.
 * Assumes straps and the sync request arrive asynchronously on pins, while
 * error flags and conversion results come from logic on clock_in.
 * Straps count only at boot and on sync edges.
 * Outputs all come from flip-flops.
 * A too slow bit clock raises overrun.
 */
`timescale 1ns/1ns
module pin_strap_mode_decoder #(
	parameter int CHANNELS = 8
) (
	input  wire logic                            clock_in,
	input  wire logic                            reset_n_in,
	input  wire logic [3:0]                      operating_select_pins_in,
	input  wire logic                            standby_bank_low_in,
	input  wire logic                            standby_bank_high_in,
	input  wire logic                            response_select_in,
	input  wire logic                            rate_select_high_in,
	input  wire logic                            rate_select_low_in,
	input  wire logic                            sync_request_in,
	input  wire logic                            crc_error_in,
	input  wire logic                            memory_flip_in,
	input  wire logic                            clock_missing_in,
	input  wire logic [CHANNELS-1:0]             filter_not_settled_in,
	input  wire logic [CHANNELS-1:0]             filter_saturated_in,
	input  wire logic [CHANNELS*24-1:0]          conversion_data_in,
	output pin_strap_pkg::power_mode_t           power_mode_out,
	output logic      [5:0]                      modulator_divide_out,
	output logic      [1:0]                      bit_clock_divider_out,
	output logic                                 one_shot_out,
	output logic                                 filter_sinc5_out,
	output logic      [10:0]                     decimation_ratio_out,
	output logic      [CHANNELS-1:0]             channel_standby_out,
	output logic                                 common_mode_output_enable_out,
	output logic                                 crystal_enable_out,
	output logic                                 reset_needed_out,
	output logic                                 output_word_rate_out,
	output logic                                 serial_bit_clock_out,
	output logic      [CHANNELS-1:0]             serial_data_lanes_out,
	output logic                                 overrun_out
);
	import pin_strap_pkg::*;

	// ==========================================================================
	// Local constants
	// ==========================================================================
	// The crystal drive hangs off channel 4, or channel 2 on the small variant.
	localparam int XTAL_CH = (CHANNELS == 4) ? 2 : 4;

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		// Boot and sync edge.
		logic [2:0]                          boot;
		logic                                sync_last;
		// Latched straps, error flag and restart strobe.
		power_mode_t                         power;
		logic [5:0]                          mod_div;
		logic [1:0]                          bclk_sel;
		logic                                one_shot;
		logic                                sinc5;
		logic [10:0]                         dec_ratio;
		logic [CHANNELS-1:0]                 standby;
		logic                                cm_en;
		logic                                xtal_en;
		logic                                err;
		logic                                restart;
		// Serialiser.
		logic                                active;
		logic [5:0]                          bits_left;
		logic [3:0]                          phase;
		logic [CHANNELS-1:0][WORD_BITS-1:0]  sh;
		logic [CHANNELS-1:0]                 lanes;
		logic                                bclk;
		logic                                word_strobe;
		logic                                overrun;
	} top_state_t;

	top_state_t st_q;
	top_state_t st_d;

	// ==========================================================================
	// Wires
	// ==========================================================================
	// Sync order: mode, standby, filter, rate, sync.
	logic [SYNC_PIN_COUNT-1:0]          pins_raw;
	logic [SYNC_PIN_COUNT-1:0]          pins_lvl;
	logic [3:0]                         mode_lvl;
	logic                               st_low_lvl;
	logic                               st_high_lvl;
	logic                               resp_lvl;
	logic [1:0]                         rate_lvl;
	logic                               sync_lvl;
	op_setting_t                        op_w;
	logic [CHANNELS-1:0]                standby_w;
	logic [CHANNELS-1:0][WORD_BITS-1:0] word_w;
	logic                               apply_w;
	logic                               error_w;
	logic                               word_tick;
	logic [3:0]                         div_w;

	// ==========================================================================
	// Pin synchronisation
	// ==========================================================================
	// Straps and sync share one synchroniser so they settle together.
	assign pins_raw = {sync_request_in, rate_select_high_in, rate_select_low_in,
		response_select_in, standby_bank_high_in, standby_bank_low_in,
		operating_select_pins_in};

	pin_sync #(
		.WIDTH (SYNC_PIN_COUNT)
	) u_pin_sync (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.pins_in    (pins_raw),
		.level_out  (pins_lvl)
	);

	// Unpack the filtered levels.
	assign mode_lvl    = pins_lvl[3:0];
	assign st_low_lvl  = pins_lvl[4];
	assign st_high_lvl = pins_lvl[5];
	assign resp_lvl    = pins_lvl[6];
	assign rate_lvl    = pins_lvl[8:7];
	assign sync_lvl    = pins_lvl[9];

	// ==========================================================================
	// Strap decoding
	// ==========================================================================
	// One decode serves every channel, so all channels share the setting.
	assign op_w = decode_operating(mode_lvl);

	// Bank of four per standby pin; the small variant uses only the low pin.
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_standby
		if (CHANNELS == 4 || ch < 4) begin : g_low
			assign standby_w[ch] = st_low_lvl;
		end else begin : g_high
			assign standby_w[ch] = st_high_lvl;
		end
	end

	// Apply on the first filtered cycle after reset, then only on a sync edge.
	// Holding sync high applies only once.
	assign apply_w = (st_q.boot == 3'h1) || (sync_lvl && !st_q.sync_last);

	// Any one fault asks for a reset.
	assign error_w = crc_error_in | memory_flip_in | clock_missing_in;

	// ==========================================================================
	// Word assembly
	// ==========================================================================
	// Header: reset needed, not settled, saturated, filter type, four zeros.
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_word
		// Live errors show at once.
		logic [HDR_BITS-1:0] hdr;
		always_comb begin
			hdr                   = '0;
			hdr[HDR_RESET_NEEDED] = st_q.err | error_w;
			hdr[HDR_NOT_SETTLED]  = filter_not_settled_in[ch];
			hdr[HDR_SATURATED]    = filter_saturated_in[ch];
			hdr[HDR_FILTER_SINC5] = st_q.sinc5;
		end
		// A standby channel keeps its slot but sends zeros.
		assign word_w[ch] = st_q.standby[ch] ? '0 :
			{hdr, conversion_data_in[ch*DATA_BITS +: DATA_BITS]};
	end

	// ==========================================================================
	// Word pacing
	// ==========================================================================
	// The timer only paces; lanes shift below.
	word_rate_timer u_word_rate_timer (
		.clock_in      (clock_in),
		.reset_n_in    (reset_n_in),
		.restart_in    (st_q.restart),
		.mod_div_in    (st_q.mod_div),
		.dec_ratio_in  (st_q.dec_ratio),
		.one_shot_in   (st_q.one_shot),
		.word_tick_out (word_tick)
	);

	// Bit period in master clocks: 1, 2, 4 or 8.
	assign div_w = 4'h1 << st_q.bclk_sel;

	// ==========================================================================
	// Next state
	// ==========================================================================
	// Configuration, error capture and the lane serialiser in one place.
	always_comb begin
		// Strobes default low.
		st_d             = st_q;
		st_d.restart     = 1'b0;
		st_d.word_strobe = 1'b0;
		st_d.sync_last   = sync_lvl;

		// Boot delay lets the pin filter settle.
		if (st_q.boot != 3'h0) begin
			st_d.boot = st_q.boot - 3'h1;
		end

		// Latch the straps; power mode drives bias and clock division as one.
		if (apply_w) begin
			st_d.power     = op_w.power;
			st_d.mod_div   = modulator_divide(op_w.power);
			st_d.bclk_sel  = op_w.bclk_sel;
			st_d.one_shot  = op_w.one_shot;
			st_d.sinc5     = resp_lvl;
			st_d.dec_ratio = decimation_ratio(rate_lvl);
			st_d.standby   = standby_w;
			st_d.cm_en     = !standby_w[0];
			st_d.xtal_en   = !standby_w[XTAL_CH];
			st_d.restart   = 1'b1;
			st_d.overrun   = 1'b0;
		end

		// The reset-needed flag holds until the block itself is reset.
		if (error_w) begin
			st_d.err = 1'b1;
		end

		// A new word while one is still shifting means the divider is too slow.
		// A word due at apply is dropped; it would mix banks.
		if (word_tick && !apply_w) begin
			if (st_q.active) begin
				st_d.overrun = 1'b1;
			end
			st_d.active      = 1'b1;
			st_d.bits_left   = LAST_BIT_INDEX;
			st_d.phase       = '0;
			st_d.word_strobe = 1'b1;
			for (int ch = 0; ch < CHANNELS; ch++) begin
				st_d.lanes[ch] = word_w[ch][WORD_BITS-1];
				st_d.sh[ch]    = word_w[ch] << 1;
			end
		end else if (st_q.active) begin
			// Shift at the end of each bit.
			if (st_q.phase == div_w - 4'h1) begin
				st_d.phase = '0;
				if (st_q.bits_left == 6'h00) begin
					st_d.active = 1'b0;
					st_d.lanes  = '0;
					st_d.sh     = '0;
				end else begin
					st_d.bits_left = st_q.bits_left - 6'h01;
					for (int ch = 0; ch < CHANNELS; ch++) begin
						st_d.lanes[ch] = st_q.sh[ch][WORD_BITS-1];
						st_d.sh[ch]    = st_q.sh[ch] << 1;
					end
				end
			end else begin
				st_d.phase = st_q.phase + 4'h1;
			end
		end

		// High in the first half of each bit; at divide-by-1 it marks valid bits.
		st_d.bclk = st_d.active && ((div_w == 4'h1) || (st_d.phase < (div_w >> 1)));
	end

	// ==========================================================================
	// State register
	// ==========================================================================
	// Reset values keep every channel on until the first strap sample lands.
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			// Cold values: low power, all on.
			st_q           <= '0;
			st_q.boot      <= BOOT_CYCLES;
			st_q.power     <= PM_LOW;
			st_q.mod_div   <= MOD_DIV_LOW;
			st_q.dec_ratio <= DEC_X32;
			st_q.cm_en     <= 1'b1;
			st_q.xtal_en   <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	// Plain views of the state.
	assign power_mode_out                = st_q.power;
	assign modulator_divide_out          = st_q.mod_div;
	assign bit_clock_divider_out         = st_q.bclk_sel;
	assign one_shot_out                  = st_q.one_shot;
	assign filter_sinc5_out              = st_q.sinc5;
	assign decimation_ratio_out          = st_q.dec_ratio;
	assign channel_standby_out           = st_q.standby;
	assign common_mode_output_enable_out = st_q.cm_en;
	assign crystal_enable_out            = st_q.xtal_en;
	assign reset_needed_out              = st_q.err;
	assign output_word_rate_out          = st_q.word_strobe;
	assign serial_bit_clock_out          = st_q.bclk;
	assign serial_data_lanes_out         = st_q.lanes;
	assign overrun_out                   = st_q.overrun;

endmodule // pin_strap_mode_decoder

// ==== sim/strap_checker.sv ====
/* Port assertions for the strap decoder.
 * Assumes one clock and a bind onto the top module. */
`timescale 1ns/1ns
module strap_checker #(
	parameter int CHANNELS = 8
) (
	input wire logic                        clock_in,
	input wire logic                        reset_n_in,
	input wire logic                        sync_request_in,
	input wire logic                        crc_error_in,
	input wire logic                        memory_flip_in,
	input wire logic                        clock_missing_in,
	input wire pin_strap_pkg::power_mode_t  power_mode_out,
	input wire logic [5:0]                  modulator_divide_out,
	input wire logic [1:0]                  bit_clock_divider_out,
	input wire logic                        one_shot_out,
	input wire logic [10:0]                 decimation_ratio_out,
	input wire logic [CHANNELS-1:0]         channel_standby_out,
	input wire logic                        common_mode_output_enable_out,
	input wire logic                        crystal_enable_out,
	input wire logic                        reset_needed_out,
	input wire logic                        output_word_rate_out,
	input wire logic                        serial_bit_clock_out,
	input wire logic [CHANNELS-1:0]         serial_data_lanes_out
);
	import pin_strap_pkg::*;
	localparam int XI = (CHANNELS == 4) ? 2 : 4;
	logic [3:0] quiet_q;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	// ==========================================
	// Sync quiet time, so a pending apply cannot land inside a bit check.
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) quiet_q <= 4'h0;
		else if (sync_request_in) quiet_q <= 4'h0;
		else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
	end
	// ==========================================
	// Assertions.
	mod_div_a: assert property (modulator_divide_out ==
		(power_mode_out == PM_FAST ? 6'h04 : power_mode_out == PM_MEDIAN ? 6'h08 : 6'h20))
		else $error("modulator divide wrong");
	one_shot_a: assert property (one_shot_out && bit_clock_divider_out != 2'h0 |->
		power_mode_out == PM_FAST && bit_clock_divider_out == 2'h1) else $error("one-shot pair");
	dec_legal_a: assert property (decimation_ratio_out inside {11'h020, 11'h040, 11'h080,
		11'h400}) else $error("decimation illegal");
	cm_follow_a: assert property (common_mode_output_enable_out == !channel_standby_out[0])
		else $error("common mode enable");
	xtal_follow_a: assert property (crystal_enable_out == !channel_standby_out[XI])
		else $error("crystal enable");
	bank_whole_a: assert property (channel_standby_out[3:0] inside {4'h0, 4'hF} &&
		channel_standby_out[CHANNELS-1:CHANNELS-4] inside {4'h0, 4'hF}) else $error("bank split");
	err_set_a: assert property (crc_error_in || memory_flip_in || clock_missing_in |->
		##[1:2] reset_needed_out) else $error("error not flagged");
	err_sticky_a: assert property (reset_needed_out |=> reset_needed_out)
		else $error("error flag dropped");
	standby_zero_a: assert property (output_word_rate_out |->
		(serial_data_lanes_out & channel_standby_out) == '0) else $error("standby lane busy");
	half_bit_a: assert property (output_word_rate_out && bit_clock_divider_out == 2'h1 &&
		quiet_q > 4'h7 |-> serial_bit_clock_out ##1 (!serial_bit_clock_out &&
		$stable(serial_data_lanes_out)) ##1 serial_bit_clock_out) else $error("bit timing");
	word_c: cover property (output_word_rate_out);
	error_c: cover property ($rose(reset_needed_out));
	one_shot_c: cover property (one_shot_out);
endmodule // strap_checker
bind pin_strap_mode_decoder strap_checker #(.CHANNELS(CHANNELS)) checker_i (.*);

// ==== sim/strap_host.sv ====
/* Host model that reads the serial lanes, one sample per bit period.
 * Assumes the divider select it sees is the one the block shifts with. */
`timescale 1ns/1ns
module strap_host #(
	parameter int CHANNELS = 8
) (
	input wire logic                  clock_in,
	input wire logic                  reset_n_in,
	input wire logic                  word_start_in,
	input wire logic [1:0]            bit_div_sel_in,
	input wire logic [CHANNELS-1:0]   lanes_in,
	output logic     [CHANNELS*32-1:0] words_out,
	output logic                      word_valid_out
);
	logic [31:0] shift_q [CHANNELS];
	logic [3:0]  tick_q;
	logic [5:0]  nbits_q;
	logic        busy_q;
	// Samples at the strobe, then every bit period; a new strobe restarts the word.
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_q <= 1'b0;
			tick_q <= 4'h0;
			nbits_q <= 6'h0;
			word_valid_out <= 1'b0;
		end else begin
			word_valid_out <= 1'b0;
			if (word_start_in || (busy_q && tick_q == (4'h1 << bit_div_sel_in))) begin
				for (int c = 0; c < CHANNELS; c++) shift_q[c] <= {shift_q[c][30:0], lanes_in[c]};
				tick_q <= 4'h1;
				nbits_q <= word_start_in ? 6'h1 : nbits_q + 6'h1;
				busy_q <= word_start_in || nbits_q != 6'h1F;
				word_valid_out <= !word_start_in && nbits_q == 6'h1F;
			end else if (busy_q) tick_q <= tick_q + 4'h1;
		end
	end
	// Lanes are handed back packed, lane c at bits c*32.
	always_comb for (int c = 0; c < CHANNELS; c++) words_out[c*32 +: 32] = shift_q[c];
endmodule // strap_host

// ==== sim/tb.sv ====
/* Bench for the strap decoder: code sweep, word stream, error flags.
 * Assumes the design package and the host model are compiled first. */
`timescale 1ns/1ns
module tb;
	import pin_strap_pkg::*;
	localparam int CH = 8;
	logic clock_in = 0, reset_n_in = 0, sync_request_in = 0, sb_lo = 0, sb_hi = 0;
	logic resp = 0, rate_hi = 0, rate_lo = 0, one_shot, sinc5, cm_en, xt_en, rst_need;
	logic strobe, bclk, valid, ovr;
	logic [3:0] op_pins = 4'h0;
	logic [2:0] err = 3'h0;
	logic [CH-1:0] not_settled = '0, saturated = '0, stby, lanes;
	logic [CH*24-1:0] data = '0;
	logic [CH*32-1:0] words, e;
	logic [CH*32-1:0] expq [$];
	power_mode_t pm;
	logic [5:0] mdiv;
	logic [1:0] bdiv, epm, ediv;
	logic [10:0] dec;
	logic [31:0] r;
	int miscompares = 0, n_checks = 0, seed = 77036, cycles = 0;
	pin_strap_mode_decoder #(.CHANNELS(CH)) DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.operating_select_pins_in(op_pins), .standby_bank_low_in(sb_lo),
		.standby_bank_high_in(sb_hi), .response_select_in(resp), .rate_select_high_in(rate_hi),
		.rate_select_low_in(rate_lo), .sync_request_in(sync_request_in), .crc_error_in(err[0]),
		.memory_flip_in(err[1]), .clock_missing_in(err[2]), .filter_not_settled_in(not_settled),
		.filter_saturated_in(saturated), .conversion_data_in(data), .power_mode_out(pm),
		.modulator_divide_out(mdiv), .bit_clock_divider_out(bdiv), .one_shot_out(one_shot),
		.filter_sinc5_out(sinc5), .decimation_ratio_out(dec), .channel_standby_out(stby),
		.common_mode_output_enable_out(cm_en), .crystal_enable_out(xt_en),
		.reset_needed_out(rst_need), .output_word_rate_out(strobe), .serial_bit_clock_out(bclk),
		.serial_data_lanes_out(lanes), .overrun_out(ovr));
	strap_host #(.CHANNELS(CH)) host_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
		.word_start_in(strobe), .bit_div_sel_in(bdiv), .lanes_in(lanes), .words_out(words),
		.word_valid_out(valid));
	always #20 clock_in = ~clock_in;
	// ==========================================
	task automatic check(input logic [CH*32-1:0] seen, input logic [CH*32-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clock_in);
			#2;
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Sync pulse with margins wider than the pin filter needs.
	task automatic apply();
		sync_request_in = 1'b1;
		tick(4);
		sync_request_in = 1'b0;
		tick(12);
	endtask
	// Skips the word in flight, so notes only match words loaded from current inputs.
	task automatic expect_stream(input logic need, input int n);
		int k;
		k = 0;
		while (valid !== 1'b1 && k < 2000) begin
			tick(1);
			k++;
		end
		tick(1);
		for (int c = 0; c < CH; c++) e[c*32 +: 32] = (c < 4 ? sb_lo : sb_hi) ? 32'h0 :
			{need, not_settled[c], saturated[c], resp, 4'h0, data[c*24 +: 24]};
		repeat (n) expq.push_back(e);
		while (expq.size() > 0 && k < 2000) begin
			tick(1);
			k++;
		end
		if (k >= 2000) miscompares++;
	endtask
	// Each word the host finishes while notes wait is compared with the oldest note.
	always @(posedge clock_in) begin
		if (valid === 1'b1 && expq.size() > 0) check(words, expq.pop_front());
	end
	// A hang ends the run as a failure.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ==========================================
	initial begin
		tick(4);
		check({pm, mdiv, dec, cm_en}, {PM_LOW, 6'h20, 11'h020, 1'b1});
		reset_n_in = 1'b1;
		for (int code = 0; code < 16; code++) begin
			r = $random(seed);
			op_pins = code[3:0];
			{rate_hi, rate_lo, resp, sb_hi, sb_lo} = r[4:0];
			apply();
			epm = code < 12 ? code[3:2] : (code > 13 ? 2'h2 : code[1:0]);
			ediv = code < 12 ? code[1:0] : {1'b0, code == 14};
			e = {epm, ediv, code > 11, epm == 2 ? 6'h04 : epm == 1 ? 6'h08 : 6'h20};
			check({pm, bdiv, one_shot, mdiv}, e);
			e = {11'h020 << (rate_hi ? (rate_lo ? 5 : 2) : rate_lo), resp, {4{sb_hi}}, {4{sb_lo}}};
			check({dec, sinc5, stby, cm_en, xt_en}, {e[19:0], !sb_lo, !sb_hi});
		end
		$display("code sweep done");
		op_pins = 4'h9;
		{rate_hi, rate_lo, resp, sb_hi, sb_lo} = 5'b00101;
		data = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
			$random(seed)};
		r = $random(seed);
		not_settled = r[CH-1:0];
		saturated = r[2*CH-1:CH];
		apply();
		expect_stream(1'b0, 2);
		check(ovr, 1'b0);
		op_pins = 4'h0;
		tick(12);
		check(bdiv, 2'h1);
		op_pins = 4'h9;
		$display("stream done");
		for (int k = 0; k < 3; k++) begin
			err = 3'h1 << k;
			tick(1);
			err = 3'h0;
			tick(3);
			check(rst_need, 1'b1);
			expect_stream(1'b1, 1);
			reset_n_in = 1'b0;
			tick(2);
			reset_n_in = 1'b1;
			tick(8);
			check(rst_need, 1'b0);
		end
		$display("error flags done");
		op_pins = 4'hB;
		apply();
		tick(300);
		check(ovr, 1'b1);
		$display("overrun done");
		give_verdict();
	end
endmodule // tb
